// File: verilog/swdu_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "swdu_map.svh"
module swdu_divider #(
  parameter int STEPS = `SWDU_WIDTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // divide issue
  input wire logic div_start,
  input wire swdu_pkg::swdu_word_t dividend_src,
  input wire swdu_pkg::swdu_word_t divisor_src,
  // result reads
  input wire logic move_from_quotient_reg,
  input wire logic move_from_remainder_reg,
  output logic read_stall,
  output logic busy,
  output logic done,
  // result registers
  output swdu_pkg::swdu_word_t quotient_reg,
  output swdu_pkg::swdu_word_t remainder_reg
);
  import swdu_pkg::*;

  // ****************************************
  // working state
  // ****************************************
  swdu_state_t state;
  logic [5:0] count;
  swdu_word_t work_rem;
  swdu_word_t work_quot;
  swdu_word_t div_mag;
  logic quot_neg;
  logic rem_neg;
  logic reset_meta_n;
  logic reset_sync_n;
  logic last_step;
  logic start_ok;
  swdu_step_if sif ();

  // ****************************************
  // step unit
  // ****************************************
  // one restoring step per run cycle, on magnitudes only
  assign sif.part_rem = work_rem;
  assign sif.part_quot = work_quot;
  assign sif.divisor_mag = div_mag;

  swdu_step u_step (
    .sif(sif)
  );

  // ****************************************
  // reset release
  // ****************************************
  // pin reset asserts at once, releases on the second edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  assign last_step = (count == 6'(STEPS - 1));
  // a start is taken outside the run phase only
  assign start_ok = div_start && (state != SWDU_RUN);

  // (RL6) multi-cycle sequence
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      state <= SWDU_IDLE;
    end else begin
      case (state)
        SWDU_IDLE: begin
          if (div_start) begin
            state <= SWDU_RUN;
          end
        end
        SWDU_RUN: begin
          if (last_step) begin
            state <= SWDU_FIX;
          end
        end
        SWDU_FIX: begin
          // (RL9) back-to-back divide
          if (div_start) begin
            state <= SWDU_RUN;
          end else begin
            state <= SWDU_IDLE;
          end
        end
        default: begin
          state <= SWDU_IDLE;
        end
      endcase
    end
  end

  // step counter, cleared by every accepted start
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      count <= 6'h00;
    end else if (start_ok) begin
      count <= 6'h00;
    end else if (state == SWDU_RUN) begin
      count <= count + 6'h01;
    end
  end

  // ****************************************
  // operand capture
  // ****************************************
  // (RL1) signed operand capture
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      div_mag <= 32'h00000000;
    end else if (start_ok) begin
      div_mag <= divisor_src[31] ? 32'(-divisor_src) : divisor_src;
    end
  end

  // (RL10) sign of results
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      quot_neg <= 1'b0;
      rem_neg <= 1'b0;
    end else if (start_ok) begin
      quot_neg <= dividend_src[31] ^ divisor_src[31];
      rem_neg <= dividend_src[31];
    end
  end

  // ****************************************
  // shift-subtract datapath
  // ****************************************
  // (RL5) zero divisor still runs all steps
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      work_rem <= 32'h00000000;
      work_quot <= 32'h00000000;
    end else if (start_ok) begin
      work_rem <= 32'h00000000;
      work_quot <= dividend_src[31] ? 32'(-dividend_src) : dividend_src;
    end else if (state == SWDU_RUN) begin
      work_rem <= sif.next_rem;
      work_quot <= sif.next_quot;
    end
  end

  // ****************************************
  // result registers
  // ****************************************
  // (RL4) no exception path
  // (RL2) quotient write
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      quotient_reg <= `SWDU_QUOT_RESET;
    end else if (state == SWDU_FIX) begin
      quotient_reg <= quot_neg ? 32'(-work_quot) : work_quot;
    end
  end

  // (RL3) remainder write
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      remainder_reg <= `SWDU_REM_RESET;
    end else if (state == SWDU_FIX) begin
      remainder_reg <= rem_neg ? 32'(-work_rem) : work_rem;
    end
  end

  // ****************************************
  // status and interlock
  // ****************************************
  // (RL11) busy flag
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      busy <= 1'b0;
    end else begin
      busy <= div_start || (state == SWDU_RUN);
    end
  end

  // one-cycle pulse alongside the result load
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      done <= 1'b0;
    end else begin
      done <= (state == SWDU_FIX);
    end
  end

  // (RL7) read interlock
  // (RL8) stall is registered, so a read first made in an issue or run cycle is not stalled in that cycle
  always_ff @(posedge core_clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      read_stall <= 1'b0;
    end else begin
      read_stall <= (move_from_quotient_reg || move_from_remainder_reg)
        && (div_start || state == SWDU_RUN);
    end
  end
endmodule : swdu_divider
`default_nettype wire

// File: common/swdu_map.svh
// Overview of operation
// (RL1) divide signed 32-bit dividend by divisor
// (RL2) completion writes full quotient register
// (RL3) completion writes full remainder register
// (RL4) never raise any arithmetic exception
// (RL5) zero divisor still completes, values unspecified
// (RL6) divide runs multi-cycle beside other instructions
// (RL7) result reads stall until results ready; stall is registered, so a read's first cycle is not stalled
// (RL8) overlapped results equal sequential results
// (RL9) no spacing needed between read and divide
// (RL10) quotient truncates, remainder follows dividend sign
// (RL11) busy from issue until results written
`ifndef SWDU_MAP_SVH
`define SWDU_MAP_SVH
`define SWDU_WIDTH 32
`define SWDU_QUOT_RESET 32'h00000000
`define SWDU_REM_RESET 32'h00000000
`endif

// File: common/swdu_pkg.sv
package swdu_pkg;
  typedef logic [31:0] swdu_word_t;
  typedef enum logic [1:0] {
    SWDU_IDLE,
    SWDU_RUN,
    SWDU_FIX
  } swdu_state_t;
endpackage : swdu_pkg

// File: common/swdu_step_if.sv
`timescale 1ns/1ps
`default_nettype none
interface swdu_step_if;
  logic [31:0] part_rem;
  logic [31:0] part_quot;
  logic [31:0] divisor_mag;
  logic [31:0] next_rem;
  logic [31:0] next_quot;
  modport core (output part_rem, output part_quot, output divisor_mag,
    input next_rem, input next_quot);
  modport step (input part_rem, input part_quot, input divisor_mag,
    output next_rem, output next_quot);
endinterface : swdu_step_if
`default_nettype wire

// File: verilog/swdu_step.sv
`timescale 1ns/1ps
`default_nettype none
module swdu_step (
  swdu_step_if.step sif
);
  logic [32:0] trial;
  logic [32:0] diff;
  // one restoring shift-subtract step
  always_comb begin
    trial = {sif.part_rem, sif.part_quot[31]};
    diff = trial - {1'b0, sif.divisor_mag};
    if (!diff[32]) begin
      sif.next_rem = diff[31:0];
      sif.next_quot = {sif.part_quot[30:0], 1'b1};
    end else begin
      sif.next_rem = trial[31:0];
      sif.next_quot = {sif.part_quot[30:0], 1'b0};
    end
  end
endmodule : swdu_step
`default_nettype wire

// File: tb/swdu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module swdu_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic div_start,
  input wire logic move_from_quotient_reg,
  input wire logic read_stall,
  input wire logic busy,
  input wire logic done,
  input wire swdu_pkg::swdu_word_t quotient_reg,
  input wire swdu_pkg::swdu_word_t remainder_reg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_BSET: assert property (div_start |=> busy)
    else $error("busy");
  AST_BLEN: assert property ($rose(busy) |-> ##32 busy)
    else $error("short");
  AST_DONE: assert property ($rose(busy) |-> ##33 done)
    else $error("done");
  AST_PULSE: assert property (done |=> !done)
    else $error("pulse");
  AST_QLOAD: assert property ($changed(quotient_reg) |-> done)
    else $error("quot");
  AST_RLOAD: assert property ($changed(remainder_reg) |-> done)
    else $error("rem");
  AST_STALL: assert property ($rose(busy) && move_from_quotient_reg |=> read_stall)
    else $error("stall");
  AST_IDLE: assert property (!busy && !div_start |=> !busy)
    else $error("idle");
endmodule : swdu_monitor
`default_nettype wire

// File: tb/swdu_pipe.sv
`timescale 1ns/1ps
`default_nettype none
module swdu_pipe (
  input wire logic core_clk,
  input wire logic want_read,
  input wire logic read_stall,
  output var logic move_from_quotient_reg = 1'b0,
  output var logic move_from_remainder_reg = 1'b0
);
  always @(posedge core_clk) begin
    move_from_quotient_reg <= want_read || (read_stall && move_from_quotient_reg);
    move_from_remainder_reg <= want_read || (read_stall && move_from_remainder_reg);
  end
endmodule : swdu_pipe
`default_nettype wire

// File: tb/test_signed_word_divide_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_signed_word_divide_unit;
  import swdu_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, div_start = 1'b0, want_read = 1'b0;
  logic move_from_quotient_reg, move_from_remainder_reg, read_stall, busy, done;
  swdu_word_t dividend_src = 32'h0, divisor_src = 32'h0, quotient_reg, remainder_reg;
  int mismatches = 0, n_compared = 0, cycles = 0;
  swdu_divider DUT (.*);
  swdu_pipe PIPE (.*);
  task automatic check(input swdu_word_t got, input swdu_word_t exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %h %h", $time, got, exp);
    end
  endtask : check
  task automatic issue(input swdu_word_t a, input swdu_word_t b);
    @(posedge core_clk);
    dividend_src <= a;
    divisor_src <= b;
    div_start <= 1'b1;
    @(posedge core_clk);
    div_start <= 1'b0;
  endtask : issue
  task automatic wait_done;
    repeat (40) if (done !== 1'b1) @(posedge core_clk) #1;
    check({31'h0, done}, 32'h1);
  endtask : wait_done
  task automatic t_table;
    swdu_word_t a[4] = '{32'hFFFFFFF9, 32'h7, 32'h80000000, 32'hFFFFFFF9};
    swdu_word_t b[4] = '{32'h2, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFE};
    swdu_word_t q;
    want_read <= 1'b1;
    foreach (a[i]) begin
      q = (a[i] == 32'h80000000 && b[i] == 32'hFFFFFFFF) ? $signed(a[i]) : $signed(a[i]) / $signed(b[i]);
      issue(a[i], b[i]);
      wait_done();
      check(quotient_reg, q);
      check(remainder_reg, a[i] - q * b[i]);
    end
    want_read <= 1'b0;
  endtask : t_table
  task automatic t_zero;
    issue(32'h5, 32'h0);
    wait_done();
  endtask : t_zero
  task automatic t_back;
    issue(32'h64, 32'hA);
    repeat (31) @(posedge core_clk);
    issue(32'hFFFFFF9C, 32'h3);
    #1;
    check(quotient_reg, 32'hA);
    check({31'h0, done}, 32'h1);
    @(posedge core_clk) #1;
    check({31'h0, busy}, 32'h1);
    wait_done();
    check(quotient_reg, 32'hFFFFFFDF);
    check(remainder_reg, 32'hFFFFFFFF);
  endtask : t_back
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_table();
    t_zero();
    t_back();
    end_of_test();
  end
endmodule : test_signed_word_divide_unit
bind swdu_divider swdu_monitor MON (.*);
`default_nettype wire
